// ### logic/comparator_control_regs.sv
// control registers, status and interrupt logic for three comparators
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module comparator_control_regs
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] comparatorResult,
  input wire logic [2:0] irqAck,
  output logic [2:0] cmpOn,
  output logic [7:0] cmp1NegSel,
  output logic [7:0] cmp2NegSel,
  output logic [7:0] cmp3NegSel,
  output logic cmp3AltPinOn,
  output logic [2:0] irqReq,
  output logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [7:0] ctrl_reg [cmp_pkg::NUM_CMP];
  logic [7:0] negSel_reg [cmp_pkg::NUM_CMP];
  logic [2:0] irqEnable_reg;
  logic [2:0] flags;
  logic [2:0] levels;
  logic [2:0] events;
  logic [2:0] irqOn;
  logic [2:0] swClear;
  logic [2:0] ackClear;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [7:0] wByte_reg;
  logic wLane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic doWrite;
  logic [7:0] statusByte;
  logic [7:0] readByte;

  cmp_event_if evt [cmp_pkg::NUM_CMP] ();

  // byte address that answers; misaligned addresses never match
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == cmp_pkg::CTRL_OFFSET[0]) || (addr == cmp_pkg::CTRL_OFFSET[1])
      || (addr == cmp_pkg::CTRL_OFFSET[2]) || (addr == cmp_pkg::STATUS_OFFSET)
      || (addr == cmp_pkg::CLEAR_OFFSET) || (addr == cmp_pkg::ENABLE_OFFSET);
  endfunction

  // one-hot steering word for the analog negative-input switch
  function automatic logic [7:0] negOneHot(input logic [2:0] code);
    negOneHot = 8'h01 << code;
  endfunction

  // one detector per comparator, fed from its own control register
  for (genvar g = 0; g < cmp_pkg::NUM_CMP; g++)
  begin : g_cmp
    assign evt[g].on = ctrl_reg[g][cmp_pkg::ON_BIT];
    assign evt[g].trigSel = ctrl_reg[g][cmp_pkg::TRIG_HI:cmp_pkg::TRIG_LO];
    assign levels[g] = evt[g].level;
    assign events[g] = evt[g].eventPulse;
    assign irqOn[g] = ctrl_reg[g][cmp_pkg::IRQ_ON_BIT];
    cmp_event_detect u_detect
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .rawResult(comparatorResult[g]),
      .bus(evt[g])
    );
  end

  // vector taken only clears when that comparator's interrupt was on
  assign ackClear = irqAck & irqOn;
  // software clears by writing ones in the flag positions
  assign swClear = (doWrite && wLane_reg && awAddr_reg == cmp_pkg::CLEAR_OFFSET)
    ? wByte_reg[cmp_pkg::FLAG_LSB +: 3] : 3'h0;

  cmp_flag_bank u_flags
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .setPulse(events),
    .swClear(swClear),
    .ackClear(ackClear),
    .flags_reg(flags)
  );

  // write address and data are taken independently, then applied together
  assign awready = ~awHeld_reg & ~bvalid_reg;
  assign wready = ~wHeld_reg & ~bvalid_reg;
  assign doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end
    else if (doWrite)
      awHeld_reg <= 1'b0;
  end

  // only the low byte lane carries register bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wHeld_reg <= 1'b0;
      wByte_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wHeld_reg <= 1'b1;
      wByte_reg <= wdata[7:0];
      wLane_reg <= wstrb[0];
    end
    else if (doWrite)
      wHeld_reg <= 1'b0;
  end

  // write answer one cycle after both halves are in
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= cmp_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= isMapped(awAddr_reg) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid_reg <= 1'b0;
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // control registers; the reserved bit 3 of the first two is masked off
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < cmp_pkg::NUM_CMP; i++)
        ctrl_reg[i] <= cmp_pkg::CTRL_RESET;
    end
    else if (doWrite && wLane_reg)
    begin
      for (int i = 0; i < cmp_pkg::NUM_CMP; i++)
        if (awAddr_reg == cmp_pkg::CTRL_OFFSET[i])
          ctrl_reg[i] <= wByte_reg & cmp_pkg::CTRL_WMASK[i];
    end
  end

  // enable register gates the summary interrupt line
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irqEnable_reg <= cmp_pkg::ENABLE_RESET;
    else if (doWrite && wLane_reg && awAddr_reg == cmp_pkg::ENABLE_OFFSET)
      irqEnable_reg <= wByte_reg[cmp_pkg::FLAG_LSB +: 3];
  end

  // negative-input steering is registered to keep the analog switch glitch-free
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < cmp_pkg::NUM_CMP; i++)
        negSel_reg[i] <= cmp_pkg::NEG_ONEHOT_RESET;
    end
    else
    begin
      for (int i = 0; i < cmp_pkg::NUM_CMP; i++)
        negSel_reg[i] <= negOneHot(ctrl_reg[i][cmp_pkg::NEG_SEL_HI:cmp_pkg::NEG_SEL_LO]);
    end
  end

  assign cmp1NegSel = negSel_reg[0];
  assign cmp2NegSel = negSel_reg[1];
  assign cmp3NegSel = negSel_reg[2];

  // analog enables straight from the register flops
  assign cmpOn[0] = ctrl_reg[0][cmp_pkg::ON_BIT];
  assign cmpOn[1] = ctrl_reg[1][cmp_pkg::ON_BIT];
  assign cmpOn[2] = ctrl_reg[2][cmp_pkg::ON_BIT];
  assign cmp3AltPinOn = ctrl_reg[2][cmp_pkg::ALT_PIN_BIT];

  // per-comparator request waits on its own enable; summary line on the mask
  assign irqReq = flags & irqOn;
  assign irq = |(flags & irqEnable_reg);

  // shared status: flags high, synchronised results low
  assign statusByte = {flags, 1'b0, levels, 1'b0};

  // clear register is write-only and reads zero
  always_comb
  begin
    readByte = 8'h00;
    if (araddr == cmp_pkg::CTRL_OFFSET[0])
      readByte = ctrl_reg[0];
    else if (araddr == cmp_pkg::CTRL_OFFSET[1])
      readByte = ctrl_reg[1];
    else if (araddr == cmp_pkg::CTRL_OFFSET[2])
      readByte = ctrl_reg[2];
    else if (araddr == cmp_pkg::STATUS_OFFSET)
      readByte = statusByte;
    else if (araddr == cmp_pkg::ENABLE_OFFSET)
      readByte = {irqEnable_reg, 5'h00};
  end

  // read answer one cycle after the address is taken
  assign arready = ~rvalid_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cmp_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, readByte};
      rresp_reg <= isMapped(araddr) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_DECERR;
    end
    else if (rready)
      rvalid_reg <= 1'b0;
  end

  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // write and read sequences used by the checks below
  sequence s_ctrl1Write;
    doWrite && wLane_reg && (awAddr_reg == cmp_pkg::CTRL_OFFSET[0]);
  endsequence

  sequence s_ctrl3Write;
    doWrite && wLane_reg && (awAddr_reg == cmp_pkg::CTRL_OFFSET[2]);
  endsequence

  sequence s_statusRead;
    arvalid && arready && (araddr == cmp_pkg::STATUS_OFFSET);
  endsequence

  AST_ON_FOLLOWS_WRITE: assert property (
    s_ctrl1Write |=> (cmpOn[0] == $past(wByte_reg[cmp_pkg::ON_BIT])))
    else $error("comparator one enable did not follow the write");

  AST_REQ_NEEDS_ENABLE: assert property (
    irqReq[1] |-> flags[1] && ctrl_reg[1][cmp_pkg::IRQ_ON_BIT])
    else $error("comparator two requested with interrupt disabled");

  AST_RESERVED_TRIGGER: assert property (
    (evt[0].trigSel == cmp_pkg::TRIG_RSVD) |-> !events[0])
    else $error("reserved trigger code produced an event");

  AST_DIVIDER_TAP: assert property (
    (ctrl_reg[1][2:0] == cmp_pkg::NEG_DIV213) |=> (cmp2NegSel == 8'h04))
    else $error("comparator two divider tap not steered");

  AST_SHARED_PIN: assert property (
    (ctrl_reg[2][2:0] == cmp_pkg::NEG_SHARED_PIN) ##1 (ctrl_reg[2][2:0] == cmp_pkg::NEG_OWN_PIN)
      |=> (cmp3NegSel == 8'h40) && $past(cmp3NegSel == 8'h80))
    else $error("comparator three pin selection not steered");

  AST_STATUS_READ: assert property (
    s_statusRead |=> rvalid && (rdata[7:5] == $past(flags)) && (rdata[3:1] == $past(levels)))
    else $error("status read does not show flags and results");

  AST_ALT_PIN: assert property (
    s_ctrl3Write |=> (cmp3AltPinOn == $past(wByte_reg[cmp_pkg::ALT_PIN_BIT])))
    else $error("alternate pin enable did not follow the write");

  AST_RESERVED_BIT: assert property (
    s_ctrl1Write |=> !ctrl_reg[0][cmp_pkg::ALT_PIN_BIT] && !ctrl_reg[1][cmp_pkg::ALT_PIN_BIT])
    else $error("reserved bit 3 became set");

  AST_OFF_READS_LOW: assert property (
    !cmpOn[2] |-> !levels[2] && !events[2])
    else $error("disabled comparator shows a result");

  AST_FLAG_WITHOUT_ENABLE: assert property (
    events[0] && !irqOn[0] |=> flags[0] && !irqReq[0])
    else $error("flag not set while interrupt disabled");

  AST_ACK_CLEARS: assert property (
    flags[0] && irqAck[0] && irqOn[0] && !events[0] |=> !flags[0])
    else $error("taken vector did not clear the flag");

  AST_RESET_CLEAR: assert property (
    $fell(rst) |-> (cmpOn == 3'h0) && !cmp3AltPinOn && (cmp1NegSel == 8'h01))
    else $error("control state not cleared by reset");

  AST_WRITE_ANSWER: assert property (
    doWrite |=> bvalid && !awready && !wready)
    else $error("write answer missing");

  // steady, switched-on comparator three whose result moved under toggle select
  sequence s_cmp3Toggled;
    (evt[2].trigSel == cmp_pkg::TRIG_TOGGLE) && cmpOn[2] && $past(cmpOn[2])
      && (levels[2] != $past(levels[2]));
  endsequence

  AST_TOGGLE_BOTH: assert property (
    s_cmp3Toggled |-> events[2])
    else $error("toggle trigger missed a result change");

  // fall event on comparator two while it was already switched on
  sequence s_cmp2FallSeen;
    (evt[1].trigSel == cmp_pkg::TRIG_FALL) && $past(cmpOn[1]) && events[1];
  endsequence

  AST_FALL_ONLY: assert property (
    s_cmp2FallSeen |-> !levels[1] && $past(levels[1]))
    else $error("fall trigger fired without a falling result");

  AST_SW_CLEAR: assert property (
    swClear[2] && !events[2] |=> !flags[2])
    else $error("written one did not clear comparator three flag");
endmodule

// ### include/cmp_pkg.sv
// constants for the three-comparator control register bank
package cmp_pkg;
  localparam int unsigned NUM_CMP = 3;
  localparam int unsigned ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] CTRL_OFFSET [NUM_CMP] = '{8'h00, 8'h04, 8'h08};
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] CLEAR_OFFSET = 8'h10;
  localparam logic [7:0] ENABLE_OFFSET = 8'h14;
  // control field positions
  localparam int unsigned ON_BIT = 7;
  localparam int unsigned IRQ_ON_BIT = 6;
  localparam int unsigned TRIG_HI = 5;
  localparam int unsigned TRIG_LO = 4;
  localparam int unsigned ALT_PIN_BIT = 3;
  localparam int unsigned NEG_SEL_HI = 2;
  localparam int unsigned NEG_SEL_LO = 0;
  // writable bits per control register; bit 3 only lives in the third
  localparam logic [7:0] CTRL_WMASK [NUM_CMP] = '{8'hF7, 8'hF7, 8'hFF};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // trigger select codes
  localparam logic [1:0] TRIG_TOGGLE = 2'h0;
  localparam logic [1:0] TRIG_RSVD = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h3;
  // negative input select codes
  localparam logic [2:0] NEG_DIV640 = 3'h0;
  localparam logic [2:0] NEG_DIV320 = 3'h1;
  localparam logic [2:0] NEG_DIV213 = 3'h2;
  localparam logic [2:0] NEG_DIV160 = 3'h3;
  localparam logic [2:0] NEG_BANDGAP = 3'h4;
  localparam logic [2:0] NEG_CONVERTER = 3'h5;
  localparam logic [2:0] NEG_OWN_PIN = 3'h6;
  localparam logic [2:0] NEG_SHARED_PIN = 3'h7;
  localparam logic [7:0] NEG_ONEHOT_RESET = 8'h01;
  // status, clear and enable share one layout
  localparam int unsigned FLAG_LSB = 5;
  localparam int unsigned RESULT_LSB = 1;
  localparam logic [2:0] ENABLE_RESET = 3'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ### include/cmp_event_if.sv
// per-comparator link between the register bank and its event detector
interface cmp_event_if;
  logic on;
  logic [1:0] trigSel;
  logic level;
  logic eventPulse;
  modport detector (input on, input trigSel, output level, output eventPulse);
  modport owner (output on, output trigSel, input level, input eventPulse);
endinterface

// ### logic/cmp_event_detect.sv
// synchroniser and trigger-edge detector for one comparator result
module cmp_event_detect
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rawResult,
  cmp_event_if.detector bus
);
  logic syncFirst_reg;
  logic syncSecond_reg;
  logic prevLevel_reg;
  logic rise;
  logic fall;
  logic hit;

  // analog result is asynchronous; only the second flop is looked at
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncFirst_reg <= 1'b0;
      syncSecond_reg <= 1'b0;
    end
    else
    begin
      syncFirst_reg <= rawResult;
      syncSecond_reg <= syncFirst_reg;
    end
  end

  // history keeps running while off, so enabling raises no false edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prevLevel_reg <= 1'b0;
    else
      prevLevel_reg <= syncSecond_reg;
  end

  assign rise = syncSecond_reg & ~prevLevel_reg;
  assign fall = ~syncSecond_reg & prevLevel_reg;

  // trigger select; the reserved code never fires
  always_comb
  begin
    case (bus.trigSel)
      cmp_pkg::TRIG_TOGGLE: hit = rise | fall;
      cmp_pkg::TRIG_FALL: hit = fall;
      cmp_pkg::TRIG_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
  end

  // a switched-off comparator reads low and raises nothing
  assign bus.level = syncSecond_reg & bus.on;
  assign bus.eventPulse = hit & bus.on;

  AST_RISE_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.trigSel == cmp_pkg::TRIG_RISE) && bus.eventPulse |-> bus.level && !$past(bus.level))
    else $error("rise trigger fired without a rising result");
endmodule

// ### logic/cmp_flag_bank.sv
// sticky comparator interrupt flags with set winning over clear
module cmp_flag_bank
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] setPulse,
  input wire logic [2:0] swClear,
  input wire logic [2:0] ackClear,
  output logic [2:0] flags_reg
);
  logic [2:0] flags_next;

  // an event in the clearing cycle is kept
  always_comb
  begin
    flags_next = (flags_reg & ~(swClear | ackClear)) | setPulse;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flags_reg <= 3'h0;
    else
      flags_reg <= flags_next;
  end

  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
    (setPulse != 3'h0) |=> ((flags_reg & $past(setPulse)) == $past(setPulse)))
    else $error("event lost against a clear");
endmodule

// ### testbench/cmp_analog_model.sv
// behavioural analog comparator cores and interrupt vector logic
module cmp_analog_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input var int posMv [3],
  input wire logic [7:0] cmp1NegSel,
  input wire logic [7:0] cmp2NegSel,
  input wire logic [7:0] cmp3NegSel,
  input wire logic [2:0] irqReq,
  input wire logic ackOn,
  output logic [2:0] comparatorResult,
  output logic [2:0] irqAck
);
  timeunit 1ns;
  timeprecision 1ps;
  // negative level in mV per code: four taps, bandgap, converter, own pin, shared pin
  localparam int NEG_MV [8] = '{400, 800, 1202, 1600, 1100, 1500, 1800, 2000};
  // a one-hot with no bit set leaves the negative input at 0 V
  function automatic logic above(int p, logic [7:0] sel);
    int n;
    n = 0;
    for (int k = 0; k < 8; k++)
      if (sel[k])
        n = NEG_MV[k];
    return p > n;
  endfunction
  // the converter is not modelled; the bench blanks a comparator before moving its input except in the trigger and interrupt-line tests
  always_comb
  begin
    comparatorResult[0] = above(posMv[0], cmp1NegSel);
    comparatorResult[1] = above(posMv[1], cmp2NegSel);
    comparatorResult[2] = above(posMv[2], cmp3NegSel);
  end
  // vector taken: one pulse per pending request, never two in a row
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irqAck <= 3'h0;
    else
      irqAck <= ackOn ? irqReq & ~irqAck : 3'h0;
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the comparator control register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NEG_MV [8] = '{400, 800, 1202, 1600, 1100, 1500, 1800, 2000};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ackOn = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, cmp3AltPinOn, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] comparatorResult, irqAck, cmpOn, irqReq;
  logic [7:0] cmp1NegSel, cmp2NegSel, cmp3NegSel;
  int posMv [3] = '{0, 0, 0};
  int ctrlM [3] = '{0, 0, 0};
  int flagsM = 0;
  int enM = 0;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  comparator_control_regs dut
  (
    .ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .comparatorResult(comparatorResult), .irqAck(irqAck), .cmpOn(cmpOn),
    .cmp1NegSel(cmp1NegSel), .cmp2NegSel(cmp2NegSel), .cmp3NegSel(cmp3NegSel),
    .cmp3AltPinOn(cmp3AltPinOn), .irqReq(irqReq), .irq(irq)
  );

  cmp_analog_model partner
  (
    .ref_clk(ref_clk), .rst(rst), .posMv(posMv), .cmp1NegSel(cmp1NegSel),
    .cmp2NegSel(cmp2NegSel), .cmp3NegSel(cmp3NegSel), .irqReq(irqReq), .ackOn(ackOn),
    .comparatorResult(comparatorResult), .irqAck(irqAck)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled at the falling edge, so the handshake edge is the next rising one
  task automatic axWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    awaddr <= a;
    wdata <= {24'($urandom()), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge ref_clk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge ref_clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    bready <= 1'b1;
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    check(32'(bresp), 32'(er));
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  task automatic axRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge ref_clk);
      t = arready;
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    check(rdata, ed);
    check(32'(rresp), 32'(er));
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  // reference model of the shared status word: flags 7:5, live results 3:1
  function automatic logic [31:0] statusExp();
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 3; i++)
    begin
      s[5 + i] = flagsM[i];
      s[1 + i] = ctrlM[i][7] && posMv[i] > NEG_MV[ctrlM[i] & 7];
    end
    return s;
  endfunction

  task automatic wrCtrl(input int i, input logic [7:0] d);
    ctrlM[i] = d & (i == 2 ? 8'hFF : 8'hF7);
    axWrite(cmp_pkg::CTRL_OFFSET[i], d, cmp_pkg::RESP_OKAY);
  endtask

  task automatic rdStatus();
    axRead(cmp_pkg::STATUS_OFFSET, statusExp(), cmp_pkg::RESP_OKAY);
  endtask

  task automatic portCheck();
    logic [2:0] rq;
    for (int i = 0; i < 3; i++)
      rq[i] = flagsM[i] && ctrlM[i][6];
    @(negedge ref_clk);
    check(32'(cmpOn), {29'h0, ctrlM[2][7], ctrlM[1][7], ctrlM[0][7]});
    check({8'h0, cmp3NegSel, cmp2NegSel, cmp1NegSel}, (32'h1 << (ctrlM[0] & 7))
      | (32'h100 << (ctrlM[1] & 7)) | (32'h10000 << (ctrlM[2] & 7)));
    check(32'(cmp3AltPinOn), 32'(ctrlM[2][3]));
    check(32'(irqReq), 32'(rq));
    check(32'(irq), 32'(|(flagsM[2:0] & enM[7:5])));
    @(posedge ref_clk);
  endtask

  // hang guard, well above the fewer than a thousand cycles the sequence needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'h111A));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++)
      axRead(8'(4 * i), 32'h0, cmp_pkg::RESP_OKAY);
    portCheck();
    axWrite(8'h18, 8'hFF, cmp_pkg::RESP_DECERR);
    axRead(8'h18, 32'h0, cmp_pkg::RESP_DECERR);
    axWrite(cmp_pkg::STATUS_OFFSET, 8'hFF, cmp_pkg::RESP_OKAY);
    rdStatus();
    // every negative code from the shared pin down, random on and bit 3, reserved trigger
    for (int i = 0; i < 3; i++)
    begin
      posMv[i] <= 1000;
      for (int c = 7; c >= 0; c--)
      begin
        wrCtrl(i, 8'h10 | (8'($urandom()) & 8'h88) | 8'(c));
        axRead(cmp_pkg::CTRL_OFFSET[i], ctrlM[i], cmp_pkg::RESP_OKAY);
        rdStatus();
        portCheck();
      end
      // blank the comparator before its input is disturbed
      wrCtrl(i, 8'h00);
      posMv[i] <= 0;
    end
    enM = 8'hE0;
    axWrite(cmp_pkg::ENABLE_OFFSET, 8'hE0, cmp_pkg::RESP_OKAY);
    // rise then fall under each trigger code, then vector clear and software clear
    for (int i = 0; i < 3; i++)
      for (int t = 0; t < 4; t++)
      begin
        wrCtrl(i, 8'h80 | (t != 0 ? 8'h40 : 8'h00) | 8'(t << 4));
        repeat (6) @(posedge ref_clk);
        posMv[i] <= 1000;
        repeat (6) @(posedge ref_clk);
        if (t == 0 || t == 3)
          flagsM[i] = 1;
        rdStatus();
        portCheck();
        posMv[i] <= 0;
        repeat (6) @(posedge ref_clk);
        if (t == 0 || t == 2)
          flagsM[i] = 1;
        rdStatus();
        portCheck();
        ackOn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ackOn <= 1'b0;
        if (ctrlM[i][6])
          flagsM[i] = 0;
        rdStatus();
        axWrite(cmp_pkg::CLEAR_OFFSET, 8'hE0, cmp_pkg::RESP_OKAY);
        flagsM = 0;
        rdStatus();
      end
    // a set flag drives the line only while its enable bit is set
    wrCtrl(2, 8'hC0);
    posMv[2] <= 1000;
    repeat (6) @(posedge ref_clk);
    flagsM[2] = 1;
    portCheck();
    enM = 0;
    axWrite(cmp_pkg::ENABLE_OFFSET, 8'h00, cmp_pkg::RESP_OKAY);
    portCheck();
    // switched off: result reads low and no event is seen
    wrCtrl(0, 8'h40);
    posMv[0] <= 1000;
    repeat (6) @(posedge ref_clk);
    rdStatus();
    end_sim();
  end
endmodule
